// file: bench/lsc_checker.sv
/* Port assertions for the light sensor config register block.
   Assumes a synchronous active-low reset; bound to the top below. */
`timescale 1ns/10ps
module lsc_checker (
    input wire       ref_clk_i,
    input wire       nrst_i,
    input wire       int_oe_n_o,
    input wire       int_trig_o,
    input wire       conv_done_i,
    input wire [3:0] result_exp_i,
    input wire       flag_h_o,
    input wire       flag_l_o,
    input wire [1:0] op_mode_o,
    input wire [3:0] range_o,
    input wire       auto_range_o,
    input wire [3:0] conv_time_o,
    input wire       fast_standby_wake_o,
    input wire       exp_match_o,
    input wire       cfg_unsupported_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Field decodes follow the stored fields
    property p_auto; auto_range_o == (range_o == 4'hC || op_mode_o == 2'h1); endproperty
    a_auto: assert property (p_auto) else $error("auto range decode");
    property p_wake; fast_standby_wake_o |-> op_mode_o inside {2'h1, 2'h2}; endproperty
    a_wake: assert property (p_wake) else $error("quick wake outside one-shot");
    // A match needs a fixed range; forced auto-range one-shot has none
    property p_exp;
        exp_match_o == (range_o <= 4'h8 && op_mode_o != 2'h1 && result_exp_i == range_o);
    endproperty
    a_exp: assert property (p_exp) else $error("exponent match");
    property p_uns; (range_o > 4'h8 && range_o != 4'hC || conv_time_o > 4'hB) |-> cfg_unsupported_o; endproperty
    a_uns: assert property (p_uns) else $error("unsupported code missed");
    // Reset values and the causes of flag and trigger events
    property p_rst; $rose(nrst_i) |-> range_o == 4'hC && conv_time_o == 4'h8 && op_mode_o == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset fields");
    property p_fh; $rose(flag_h_o) |-> $past(conv_done_i) || $past(conv_done_i, 2); endproperty
    a_fh: assert property (p_fh) else $error("high flag without conversion");
    property p_fl; $rose(flag_l_o) |-> $past(conv_done_i) || $past(conv_done_i, 2); endproperty
    a_fl: assert property (p_fl) else $error("low flag without conversion");
    property p_trig; int_trig_o |-> int_oe_n_o ##1 !int_trig_o; endproperty
    a_trig: assert property (p_trig) else $error("input trigger");
endmodule
bind lsc_config_regs lsc_checker u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .int_oe_n_o(int_oe_n_o),
    .int_trig_o(int_trig_o), .conv_done_i(conv_done_i), .result_exp_i(result_exp_i), .flag_h_o(flag_h_o),
    .flag_l_o(flag_l_o), .op_mode_o(op_mode_o), .range_o(range_o), .auto_range_o(auto_range_o),
    .conv_time_o(conv_time_o), .fast_standby_wake_o(fast_standby_wake_o), .exp_match_o(exp_match_o),
    .cfg_unsupported_o(cfg_unsupported_o));

// file: bench/lsc_i2c_host.sv
/* I2C host model reaching the register pair.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/10ps
`include "lsc_consts.vh"
module lsc_i2c_host (
    input  wire clk_i,
    output reg  scl_o,
    output reg  sda_o,
    input  wire sda_i
);
    // Both lines released; SCL stands still outside frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One 125 ns bit; SDA only moves while SCL is low
    task automatic bit_io(input b, output r);
        sda_o = b;
        #31.25 scl_o = 1'b1;
        #31.25 r = sda_i;
        #31.25 scl_o = 1'b0;
        #31.25;
    endtask
    // START or repeated START (0), STOP (1)
    task automatic cond(input stop);
        sda_o = stop ? 1'b0 : 1'b1;
        #31.25 scl_o = 1'b1;
        #31.25 sda_o = stop;
        #31.25 scl_o = stop;
    endtask
    // One byte, then the acknowledge slot
    task automatic xfer(input [7:0] d, input ack, output [7:0] q);
        reg r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ack, r);
    endtask
    task automatic wr(input [7:0] ptr, input [15:0] v);
        reg [7:0] q;
        // Start just past a falling edge so no pin moves on a clock edge
        @(negedge clk_i);
        #0.1;
        if (ptr == `LSC_PTR_MEAS_CFG) v[14] = 1'b0;
        if (ptr == `LSC_PTR_INTB_CFG) v[15:5] = 11'h400;
        cond(1'b0);
        xfer({`LSC_I2C_ADDR, 1'b0}, 1'b1, q);
        xfer(ptr, 1'b1, q);
        xfer(v[15:8], 1'b1, q);
        xfer(v[7:0], 1'b1, q);
        cond(1'b1);
    endtask
    // Two words read after a pointer write; last byte refused
    task automatic rd(input [7:0] ptr, output [31:0] w);
        reg [7:0] q;
        @(negedge clk_i);
        #0.1;
        cond(1'b0);
        xfer({`LSC_I2C_ADDR, 1'b0}, 1'b1, q);
        xfer(ptr, 1'b1, q);
        cond(1'b0);
        xfer({`LSC_I2C_ADDR, 1'b1}, 1'b1, q);
        for (int k = 3; k >= 0; k--) begin
            xfer(8'hFF, k == 0, q);
            w = {w[23:0], q};
        end
        cond(1'b1);
    endtask
endmodule

// file: bench/test_light_sensor_config_regs.sv
/* Self-checking bench for the light sensor config block.
   Assumes the I2C host model and the bound checker. */
`timescale 1ns/10ps
module test_light_sensor_config_regs;
    reg         clk, nrst, int_pin, cdone, hi, lo, clr;
    reg  [3:0]  rexp;
    reg  [31:0] w;
    reg  [15:0] d;
    reg  [1:0]  ic;
    wire        scl, hsda, sda_o, sda_oe_n, int_o, int_oe_n, trig, fh, fl, auto_r, wake, em, uns;
    wire [1:0]  mode;
    wire [3:0]  range, ctime;
    wire        sda = hsda & (sda_oe_n | sda_o);  // Pull-up resolves the wire
    integer     miscompares, n_tests, seed, nconv, ipw, i, k, n;
    localparam [31:0] RANGES = 32'h89CF0BD5;      // Corner range codes
    // 125 MHz clock
    always #4 clk = ~clk;
    // Design and far-side host
    lsc_config_regs u_dut (.ref_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .int_i(int_pin), .int_o(int_o), .int_oe_n_o(int_oe_n), .int_trig_o(trig),
        .conv_done_i(cdone), .result_exp_i(rexp), .above_hi_i(hi), .below_lo_i(lo), .flag_clr_i(clr),
        .flag_h_o(fh), .flag_l_o(fl), .op_mode_o(mode), .range_o(range), .auto_range_o(auto_r),
        .conv_time_o(ctime), .fast_standby_wake_o(wake), .exp_match_o(em), .cfg_unsupported_o(uns));
    lsc_i2c_host u_host (.clk_i(clk), .scl_o(scl), .sda_o(hsda), .sda_i(sda));
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("%0d mismatches in %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One conversion, then count cycles with INT at level act
    task convert(input h, input l, input act);
        @(negedge clk);
        cdone = 1'b1;
        hi = h;
        lo = l;
        @(negedge clk);
        cdone = 1'b0;
        nconv = nconv + 1;
        ipw = 0;
        repeat (140) begin
            @(negedge clk);
            if (int_o === act) ipw = ipw + 1;
        end
    endtask
    // Expected {wake, auto, unsupported, exponent match}
    function [3:0] cfg_exp(input [15:0] a, input [1:0] c, input [3:0] e);
        cfg_exp[3] = a[15] && (a[5:4] == 2'h1 || a[5:4] == 2'h2);
        cfg_exp[2] = a[13:10] == 4'hC || a[5:4] == 2'h1;
        cfg_exp[1] = (a[13:10] > 4'h8 && a[13:10] != 4'hC) || a[9:6] > 4'hB || c == 2'h2;
        cfg_exp[0] = a[13:10] <= 4'h8 && a[5:4] != 2'h1 && e == a[13:10];
    endfunction
    // Hang guard: out of time counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        miscompares = miscompares + 1;
        close_out;
    end
    // Main sequence
    initial begin
        {clk, nrst, cdone, hi, lo, clr, rexp} = 0;
        int_pin = 1'b1;
        {miscompares, n_tests, nconv} = 0;
        seed = 95;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        u_host.rd(8'h0A, w);
        chk(w, 32'h3208_8011);
        chk({range, ctime, mode, int_oe_n, int_o}, {4'hC, 4'h8, 2'h0, 2'b01});
        u_host.rd(8'h20, w);
        chk(w, 0);
        for (i = 0; i < 8; i = i + 1) begin
            @(negedge clk);
            d = $random(seed);
            d[14] = 1'b0;
            d[13:10] = RANGES[28 - 4 * i +: 4];
            d[9:6] = 4'hB + i[1:0];
            d[5:4] = i[1:0];
            ic = i[2:1];
            rexp = i[0] ? d[13:10] : $random(seed);
            u_host.wr(8'h0A, d);
            u_host.wr(8'h0B, {11'h400, 1'b1, ic, 2'b01});
            u_host.rd(8'h0A, w);
            chk(w, {d, 11'h400, 1'b1, ic, 2'b01});
            chk({range, ctime, mode}, d[13:4]);
            chk({wake, auto_r, uns, em}, cfg_exp(d, ic, rexp));
        end
        u_host.wr(8'h0B, 16'h8014);
        u_host.rd(8'h0B, w);
        chk(w, 32'h8014_8014);
        u_host.wr(8'h0A, 16'h003C);
        for (k = 0; k < 3; k = k + 1) begin
            ic = k + 1;
            u_host.wr(8'h0B, {11'h400, 1'b1, ic, 2'b00});
            for (n = 0; n < 5; n = n + 1) begin
                convert(1'b0, 1'b0, 1'b1);
                chk(ipw, (ic == 2'h1 || (ic == 2'h3 && nconv % 4 == 0)) ? 125 : 0);
            end
        end
        for (k = 0; k < 4; k = k + 1) begin
            u_host.wr(8'h0A, {14'h000F, k[1:0]});
            @(negedge clk) clr = 1'b1;
            @(negedge clk) clr = 1'b0;
            for (n = 1; n <= (1 << k); n = n + 1) begin
                convert(!k[0], k[0], 1'b1);
                chk({fh, fl}, (n == (1 << k)) ? {!k[0], k[0]} : 2'b00);
            end
        end
        u_host.wr(8'h0B, 16'h8010);
        u_host.wr(8'h0A, 16'h0034);
        convert(1'b1, 1'b0, 1'b1);
        chk({fh, ipw != 0}, 2'b11);
        convert(1'b0, 1'b0, 1'b1);
        chk(fh, 0);
        u_host.wr(8'h0A, 16'h0030);
        chk(int_o, 1);
        u_host.wr(8'h0B, 16'h8000);
        chk(int_oe_n, 1);
        // Pin faces inward and is active low: only falling edges trigger
        n = 0;
        repeat (4) begin
            @(negedge clk) int_pin = ~int_pin;
            repeat (6) begin
                @(negedge clk);
                n = n + trig;
            end
        end
        chk(n, 2);
        close_out;
    end
endmodule

// file: design/lsc_config_regs.v
/*
 * Configuration register pair of an ambient light sensor, reached over an
 * I2C target port, plus the threshold fault counting and interrupt pin
 * logic that these settings steer.
 * Assumes SCL, SDA and INT come from pins outside the clock domain, and
 * that conversion results and threshold compares arrive on ref_clk_i.
 */
// What this block does
// - Quick wake kept only in one-shot modes
// - Range field, code 12 auto-range default
// - Range codes 0-8 match result exponent, except in auto-range one-shot mode
// - Conversion time codes 0 to 11
// - Two-bit mode field, resets power-down
// - Latch bit selects latched threshold reporting
// - Polarity bit sets interrupt active level
// - Fault count selects 1,2,4,8 results
// - Direction bit: interrupt pin input or output
// - Interrupt source: alert, every conversion, invalid
// - Code 3 asserts every fourth conversion
// - Burst bit advances read pointer
// - Second register resets to 8011h
// - Flags need consecutive out-of-threshold results
`timescale 1ns/10ps
`include "lsc_consts.vh"

module lsc_config_regs (
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_n_o,
    input  wire        int_i,
    output reg         int_o,
    output wire        int_oe_n_o,
    output reg         int_trig_o,
    input  wire        conv_done_i,
    input  wire [3:0]  result_exp_i,
    input  wire        above_hi_i,
    input  wire        below_lo_i,
    input  wire        flag_clr_i,
    output reg         flag_h_o,
    output reg         flag_l_o,
    output wire [1:0]  op_mode_o,
    output wire [3:0]  range_o,
    output wire        auto_range_o,
    output wire [3:0]  conv_time_o,
    output wire        fast_standby_wake_o,
    output wire        exp_match_o,
    output wire        cfg_unsupported_o
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_PTR  = 3'h2;
    localparam [2:0] S_WDAT = 3'h3;
    localparam [2:0] S_RDAT = 3'h4;
    localparam [2:0] S_IGN  = 3'h5;

    localparam [7:0] PULSE_CYC = `LSC_INT_PULSE_CYC;

    reg  [15:0] meas_q;
    reg         dir_q;
    reg  [1:0]  icfg_q;
    reg         burst_q;
    reg  [2:0]  scl_sync_q;
    reg  [2:0]  sda_sync_q;
    reg  [2:0]  int_sync_q;
    reg  [2:0]  state_q;
    reg  [2:0]  nxt_q;
    reg  [3:0]  bitc_q;
    reg         ack_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  tx_q;
    reg         drv_q;
    reg  [7:0]  ptr_q;
    reg  [7:0]  wmsb_q;
    reg         widx_q;
    reg         ridx_q;
    reg  [3:0]  cnt_h_q;
    reg  [3:0]  cnt_l_q;
    reg  [1:0]  fifo_q;
    reg  [7:0]  pulse_q;

    wire        scl_s    = scl_sync_q[1];
    wire        sda_s    = sda_sync_q[1];
    wire        scl_rise = scl_s & ~scl_sync_q[2];
    wire        scl_fall = ~scl_s & scl_sync_q[2];
    wire        start_c  = scl_s & scl_sync_q[2] & sda_sync_q[2] & ~sda_s;
    wire        stop_c   = scl_s & scl_sync_q[2] & ~sda_sync_q[2] & sda_s;
    wire [7:0]  ptr_inc  = burst_q ? (ptr_q + 8'h01) : ptr_q;
    wire        pol      = meas_q[`LSC_POL_BIT];
    wire        latch    = meas_q[`LSC_LATCH_BIT];
    wire [3:0]  need     = 4'h1 << meas_q[`LSC_FC_HI:`LSC_FC_LO];

    // Read value under the pointer; unmapped pointers read zero
    // fixed upper field
    wire [15:0] intb_word = `LSC_INTB_FIXED | {11'h000, dir_q, icfg_q, 1'b0, burst_q};
    wire [15:0] rd_cur    = (ptr_q == `LSC_PTR_MEAS_CFG) ? meas_q :
                            (ptr_q == `LSC_PTR_INTB_CFG) ? intb_word : 16'h0000;

    // Two-flop synchronisers; third stage only for edge finding
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            // INT idles high under its pull-up, so no false edge follows reset
            int_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            int_sync_q <= {int_sync_q[1:0], int_i};
        end
    end

    // I2C target engine: sample on SCL rise, drive on SCL fall
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            nxt_q   <= S_IDLE;
            bitc_q  <= 4'h0;
            ack_q   <= 1'b0;
            sh_q    <= 8'h00;
            tx_q    <= 8'h00;
            drv_q   <= 1'b0;
            ptr_q   <= 8'h00;
            wmsb_q  <= 8'h00;
            widx_q  <= 1'b0;
            ridx_q  <= 1'b0;
            meas_q  <= `LSC_MEAS_RST;
            dir_q   <= `LSC_DIR_RST;
            icfg_q  <= `LSC_ICFG_RST;
            burst_q <= `LSC_BURST_RST;
        end else if (start_c) begin
            state_q <= S_ADDR;
            bitc_q  <= 4'h0;
            ack_q   <= 1'b0;
            drv_q   <= 1'b0;
        end else if (stop_c) begin
            state_q <= S_IDLE;
            drv_q   <= 1'b0;
        end else if (state_q != S_IDLE && state_q != S_IGN) begin
            if (scl_rise) begin
                if (!ack_q) begin
                    sh_q   <= {sh_q[6:0], sda_s};
                    bitc_q <= bitc_q + 4'h1;
                end else if (state_q == S_RDAT && sda_s) begin
                    // Host NACK ends the read
                    state_q <= S_IGN;
                end
            end else if (scl_fall) begin
                if (!ack_q && bitc_q == 4'h8) begin
                    ack_q <= 1'b1;
                    case (state_q)
                        S_ADDR: begin
                            if (sh_q[7:1] == `LSC_I2C_ADDR) begin
                                drv_q <= 1'b1;
                                nxt_q <= sh_q[0] ? S_RDAT : S_PTR;
                            end else begin
                                state_q <= S_IGN;
                            end
                        end
                        S_PTR: begin
                            ptr_q  <= sh_q;
                            widx_q <= 1'b0;
                            drv_q  <= 1'b1;
                            nxt_q  <= S_WDAT;
                        end
                        S_WDAT: begin
                            drv_q  <= 1'b1;
                            nxt_q  <= S_WDAT;
                            widx_q <= ~widx_q;
                            if (!widx_q) begin
                                wmsb_q <= sh_q;
                            end else if (ptr_q == `LSC_PTR_MEAS_CFG) begin
                                meas_q <= {wmsb_q, sh_q} & ~(16'h0001 << `LSC_RSV14_BIT);
                            end else if (ptr_q == `LSC_PTR_INTB_CFG) begin
                                dir_q   <= sh_q[`LSC_DIR_BIT];
                                icfg_q  <= sh_q[`LSC_ICFG_HI:`LSC_ICFG_LO];
                                burst_q <= sh_q[`LSC_BURST_BIT];
                            end
                        end
                        S_RDAT: begin
                            drv_q <= 1'b0;
                            nxt_q <= S_RDAT;
                        end
                        default: begin
                            state_q <= S_IGN;
                        end
                    endcase
                end else if (ack_q) begin
                    ack_q   <= 1'b0;
                    bitc_q  <= 4'h0;
                    state_q <= nxt_q;
                    drv_q   <= 1'b0;
                    if (nxt_q == S_RDAT) begin
                        // Both halves come from ptr_q; the pointer only moves
                        // in the cycle the low byte is loaded into tx_q, so a word never tears
                        if (state_q == S_ADDR || !ridx_q) begin
                            ridx_q <= 1'b1;
                            tx_q   <= rd_cur[15:8];
                            drv_q  <= ~rd_cur[15];
                        end else begin
                            ridx_q <= 1'b0;
                            ptr_q  <= ptr_inc;
                            tx_q   <= rd_cur[7:0];
                            drv_q  <= ~rd_cur[7];
                        end
                    end
                end else if (state_q == S_RDAT && bitc_q != 4'h0) begin
                    drv_q <= ~tx_q[3'h7 - bitc_q[2:0]];
                end
            end
        end
    end

    // Open drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~drv_q;

    // quick wake only in one-shot modes
    assign fast_standby_wake_o = meas_q[`LSC_FAST_STANDBY_WAKE_BIT] &
        ((op_mode_o == `LSC_MODE_OS) | (op_mode_o == `LSC_MODE_OS_AUTO));
    assign op_mode_o    = meas_q[`LSC_MODE_HI:`LSC_MODE_LO];
    assign range_o      = meas_q[`LSC_RANGE_HI:`LSC_RANGE_LO];
    assign auto_range_o = (range_o == `LSC_RANGE_AUTO) | (op_mode_o == `LSC_MODE_OS_AUTO);
    assign exp_match_o  = ~auto_range_o & (range_o <= `LSC_RANGE_MAX) & (result_exp_i == range_o);
    assign conv_time_o  = meas_q[`LSC_CT_HI:`LSC_CT_LO];
    assign cfg_unsupported_o = ((range_o > `LSC_RANGE_MAX) & (range_o != `LSC_RANGE_AUTO)) |
        (conv_time_o > `LSC_CT_MAX) | (icfg_q == `LSC_ICFG_INVALID);

    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cnt_h_q  <= 4'h0;
            cnt_l_q  <= 4'h0;
            flag_h_o <= 1'b0;
            flag_l_o <= 1'b0;
        end else if (conv_done_i) begin
            cnt_h_q <= above_hi_i ? ((cnt_h_q < need) ? cnt_h_q + 4'h1 : cnt_h_q) : 4'h0;
            cnt_l_q <= below_lo_i ? ((cnt_l_q < need) ? cnt_l_q + 4'h1 : cnt_l_q) : 4'h0;
            // latched flags hold, transparent ones follow
            if (above_hi_i && cnt_h_q + 4'h1 >= need) begin
                flag_h_o <= 1'b1;
            end else if (!latch || flag_clr_i) begin
                flag_h_o <= 1'b0;
            end
            if (below_lo_i && cnt_l_q + 4'h1 >= need) begin
                flag_l_o <= 1'b1;
            end else if (!latch || flag_clr_i) begin
                flag_l_o <= 1'b0;
            end
        end else if (flag_clr_i) begin
            flag_h_o <= 1'b0;
            flag_l_o <= 1'b0;
        end
    end

    // Interrupt pin: pulse stretch so a slow host can see it
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            fifo_q     <= 2'h0;
            pulse_q    <= 8'h00;
            int_o      <= 1'b1;
            int_trig_o <= 1'b0;
        end else begin
            if (conv_done_i) begin
                fifo_q <= fifo_q + 2'h1;
            end
            if (conv_done_i && (icfg_q == `LSC_ICFG_EVERY)) begin
                pulse_q <= PULSE_CYC;
            end else if (conv_done_i && (icfg_q == `LSC_ICFG_FIFO4) && (fifo_q == `LSC_FIFO_DEPTH)) begin
                pulse_q <= PULSE_CYC;
            end else if (pulse_q != 8'h00) begin
                pulse_q <= pulse_q - 8'h01;
            end
            if (icfg_q == `LSC_ICFG_ALERT) begin
                int_o <= ~((flag_h_o | flag_l_o) ^ pol);
            end else begin
                int_o <= ~((pulse_q != 8'h00) ^ pol);
            end
            // Trigger input when the pin faces inward
            int_trig_o <= ~dir_q & ((int_sync_q[1] ^ ~pol) & ~(int_sync_q[2] ^ ~pol));
        end
    end

    assign int_oe_n_o = ~dir_q;

endmodule

// file: pkg/lsc_consts.vh
/*
 * Constants of the light sensor configuration register block: pointer
 * offsets, field positions, reset values, codes and timing counts.
 * Assumes it is included by bare name from the design file.
 */
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH

// Bus address of the device (arbitrary value)
`define LSC_I2C_ADDR        7'h45

// Register pointers
`define LSC_PTR_MEAS_CFG    8'h0A
`define LSC_PTR_INTB_CFG    8'h0B

// Reset values
`define LSC_MEAS_RST        16'h3208
`define LSC_INTB_RST        16'h8011
`define LSC_INTB_FIXED      16'h8000
`define LSC_DIR_RST         1'h1
`define LSC_ICFG_RST        2'h0
`define LSC_BURST_RST       1'h1

// Measurement config field positions
`define LSC_FAST_STANDBY_WAKE_BIT       15
`define LSC_RSV14_BIT       14
`define LSC_RANGE_HI        13
`define LSC_RANGE_LO        10
`define LSC_CT_HI           9
`define LSC_CT_LO           6
`define LSC_MODE_HI         5
`define LSC_MODE_LO         4
`define LSC_LATCH_BIT       3
`define LSC_POL_BIT         2
`define LSC_FC_HI           1
`define LSC_FC_LO           0

// Interrupt and bus config field positions
`define LSC_DIR_BIT         4
`define LSC_ICFG_HI         3
`define LSC_ICFG_LO         2
`define LSC_RSV1_BIT        1
`define LSC_BURST_BIT       0

// Codes
`define LSC_RANGE_AUTO      4'hC
`define LSC_RANGE_MAX       4'h8
`define LSC_CT_MAX          4'hB
`define LSC_MODE_PDOWN      2'h0
`define LSC_MODE_OS_AUTO    2'h1
`define LSC_MODE_OS         2'h2
`define LSC_MODE_CONT       2'h3
`define LSC_ICFG_ALERT      2'h0
`define LSC_ICFG_EVERY      2'h1
`define LSC_ICFG_INVALID    2'h2
`define LSC_ICFG_FIFO4      2'h3
`define LSC_FIFO_DEPTH      2'h3

// Timing: a 1000 ns interrupt pulse at the 125 MHz clock
`define LSC_INT_PULSE_CYC   8'h7D

`endif
